/* File: rtl/dmx_cfg.svh */
`ifndef DMX_CFG_SVH
`define DMX_CFG_SVH
// ---------------------------------------------
// Register offsets
// ---------------------------------------------
`define DMX_OFS_CTRL 8'h00
`define DMX_OFS_SYNC 8'h04
`define DMX_OFS_TEST 8'h08
`define DMX_OFS_STAT 8'h0C
`define DMX_OFS_DISP 8'h10
// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define DMX_C_TEST 0
`define DMX_C_MODE2 1
`define DMX_C_TOL 2
`define DMX_C_CHK_LO 3
`define DMX_C_MISS_LO 5
`define DMX_C_SEL_LO 8
`define DMX_T_P8_LO 0
`define DMX_T_P6_LO 8
// ---------------------------------------------
// Reset values and responses
// ---------------------------------------------
`define DMX_CTRL_RST 12'h008
`define DMX_SYNC_RST 16'h0000
`define DMX_TEST_RST 14'h0000
`define DMX_LAMP_RST 3'h1
`define DMX_RESP_OK 2'h0
`define DMX_RESP_ERR 2'h2
// ---------------------------------------------
// Counts and channel map
// ---------------------------------------------
`define DMX_N_BITS_M1 5'h1C
`define DMX_N_BITS_M2 5'h10
`define DMX_N_CHAN 12
`define DMX_CH_IR0 4'h8
`define DMX_SR_LEN 60
`define DMX_LINE_W 56
`define DMX_ST_HALF 2
`define DMX_ST_ON 2048
`define DMX_ST_OFF 512
`endif

/* File: rtl/dmx_chan_mem.sv */
`timescale 1ns/1ps
`include "dmx_cfg.svh"
module dmx_chan_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = `DMX_N_CHAN,
	parameter int AW = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];
	wire w_in = waddr < AW'(DEPTH);
	wire r_in = raddr < AW'(DEPTH);
	// Latest word of each channel; out of range reads give zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < DEPTH; i++) mem[i] <= '0;
			rdata <= '0;
		end else begin
			if (we && w_in) mem[waddr] <= wdata;
			rdata <= r_in ? mem[raddr] : '0;
		end
	end
endmodule : dmx_chan_mem

/* File: rtl/dmx_demux.sv */
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "dmx_cfg.svh"
module dmx_demux import dmx_pkg::*; #(
	parameter int SR_LEN = `DMX_SR_LEN,
	parameter int LINE_W = `DMX_LINE_W,
	parameter int ST_HALF = `DMX_ST_HALF,
	parameter int ST_ON = `DMX_ST_ON,
	parameter int ST_OFF = `DMX_ST_OFF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic demod_clk28,
	input wire logic demod_clk14,
	input wire logic demod_x,
	input wire logic demod_y,
	output logic [47:0] visual_channel_outputs,
	output logic [15:0] infrared_channel_outputs,
	output logic [LINE_W-1:0] line_word,
	output logic [2:0] sync_lamps,
	output logic [7:0] display_leds
);
	// ---------------------------------------------
	// Register bus slave
	// ---------------------------------------------
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic [11:0] ctrl;
	logic [15:0] sync_pat;
	logic [13:0] test_pat;
	logic [31:0] stat_word;
	logic [31:0] rd_data;
	// Address decode for both directions
	wire wa_ctrl = awaddr_q == `DMX_OFS_CTRL;
	wire wa_sync = awaddr_q == `DMX_OFS_SYNC;
	wire wa_test = awaddr_q == `DMX_OFS_TEST;
	wire wr_ok = wa_ctrl || wa_sync || wa_test;
	wire do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	wire ra_ctrl = s_axi_araddr == `DMX_OFS_CTRL;
	wire ra_sync = s_axi_araddr == `DMX_OFS_SYNC;
	wire ra_test = s_axi_araddr == `DMX_OFS_TEST;
	wire ra_stat = s_axi_araddr == `DMX_OFS_STAT;
	wire ra_disp = s_axi_araddr == `DMX_OFS_DISP;
	wire rd_ok = ra_ctrl || ra_sync || ra_test || ra_stat || ra_disp;
	// Byte-lane merge into the addressed word; reserved bits stay zero
	wire [31:0] wr_cur = wa_ctrl ? {20'h0_0000, ctrl} :
		wa_sync ? {16'h0000, sync_pat} : {18'h0_0000, test_pat};
	logic [31:0] wr_new;
	always_comb begin
		wr_new = wr_cur;
		for (int i = 0; i < 4; i++) begin
			if (wstrb_q[i]) wr_new[i*8 +: 8] = wdata_q[i*8 +: 8];
		end
	end
	assign rd_data = ra_ctrl ? {20'h0_0000, ctrl} :
		ra_sync ? {16'h0000, sync_pat} :
		ra_test ? {18'h0_0000, test_pat} :
		ra_stat ? stat_word :
		ra_disp ? {24'h00_0000, display_leds} : 32'h0000_0000;
	// Address and data are held separately so either may come first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DMX_RESP_OK;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_wr) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? `DMX_RESP_OK : `DMX_RESP_ERR;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// Writable registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= `DMX_CTRL_RST;
			sync_pat <= `DMX_SYNC_RST;
			test_pat <= `DMX_TEST_RST;
		end else if (do_wr) begin
			if (wa_ctrl) ctrl <= wr_new[11:0];
			if (wa_sync) sync_pat <= wr_new[15:0];
			if (wa_test) test_pat <= wr_new[13:0];
		end
	end
	// Read channel answers one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `DMX_RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_data;
			s_axi_rresp <= rd_ok ? `DMX_RESP_OK : `DMX_RESP_ERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
	// Control fields
	wire test_on = ctrl[`DMX_C_TEST];
	wire mode2 = ctrl[`DMX_C_MODE2];
	wire tol = ctrl[`DMX_C_TOL];
	wire [1:0] chk_n = ctrl[`DMX_C_CHK_LO +: 2];
	wire [1:0] miss_n = ctrl[`DMX_C_MISS_LO +: 2];
	wire [3:0] disp_sel = ctrl[`DMX_C_SEL_LO +: 4];
	// ---------------------------------------------
	// Link input and self-test source
	// ---------------------------------------------
	logic [3:0] s1;
	logic [3:0] s2;
	logic [3:0] s3;
	logic [3:0] lvl;
	dmx_link_s gen_link;
	dmx_link_s live;
	dmx_link_s prev;
	wire [3:0] pins = {demod_clk28, demod_clk14, demod_x, demod_y};
	wire [3:0] agree = ~(s2 ^ s3);
	// Three stages; a change counts only once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1 <= 4'h0;
			s2 <= 4'h0;
			s3 <= 4'h0;
			lvl <= 4'h0;
			prev <= '0;
		end else begin
			s1 <= pins;
			s2 <= s1;
			s3 <= s2;
			lvl <= (lvl & ~agree) | (s3 & agree);
			prev <= live;
		end
	end
	dmx_selftest #(
		.HALF(ST_HALF),
		.ON_CNT(ST_ON),
		.OFF_CNT(ST_OFF)
	) dmx_selftest_i (
		.aclk(aclk),
		.aresetn(aresetn),
		.enable(test_on),
		.pat8(test_pat[`DMX_T_P8_LO +: 8]),
		.pat6(test_pat[`DMX_T_P6_LO +: 6]),
		.link(gen_link)
	);
	// Self-test replaces the demodulator at the source mux
	assign live = test_on ? gen_link : dmx_link_s'(lvl);
	wire rise14 = live.clk14 && !prev.clk14;
	wire t28 = live.clk28 && !prev.clk28;
	wire live_x = live.x;
	// ---------------------------------------------
	// Shift storage
	// ---------------------------------------------
	logic [SR_LEN-1:0] x_sr;
	logic [SR_LEN-1:0] y_sr;
	// Low four bits of each chain are the parallel nibble
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			x_sr <= '0;
			y_sr <= '0;
		end else if (rise14) begin
			x_sr <= {x_sr[SR_LEN-2:0], live.x};
			y_sr <= {y_sr[SR_LEN-2:0], live.y};
		end
	end
	wire [7:0] w8 = {x_sr[3:0], y_sr[3:0]};
	wire [5:0] w6 = {x_sr[2:0], y_sr[2:0]};
	wire [15:0] seen16 = {x_sr[7:0], y_sr[7:0]};
	wire [LINE_W-1:0] line_src = {x_sr[LINE_W/2-1:0], y_sr[LINE_W/2-1:0]};
	// ---------------------------------------------
	// Word and frame counters
	// ---------------------------------------------
	logic flag;
	logic [2:0] c8;
	logic [2:0] c6;
	logic [2:0] wcnt;
	logic [1:0] fcnt;
	logic sync_reset;
	wire end8 = !flag && c8 == 3'h7;
	wire end6 = flag && c6 == 3'h5;
	wire endw = end6 && wcnt == 3'h7;
	wire slot_end = endw && fcnt == 2'h3;
	// Flag steers between the eight-bit slot and the visual words
	always_ff @(posedge aclk) begin
		if (!aresetn || sync_reset) begin
			flag <= 1'b0;
			c8 <= 3'h0;
			c6 <= 3'h0;
			wcnt <= 3'h0;
			fcnt <= 2'h0;
		end else if (t28) begin
			if (!flag) begin
				c8 <= c8 + 3'h1;
				if (end8) flag <= 1'b1;
			end else begin
				c6 <= end6 ? 3'h0 : c6 + 3'h1;
				if (end6) wcnt <= wcnt + 3'h1;
				if (endw) flag <= 1'b0;
				if (endw) fcnt <= fcnt + 2'h1;
			end
		end
	end
	// Half-rate line counters, two bits per count
	logic [4:0] bit_cnt;
	logic [1:0] line_cnt;
	wire [4:0] bit_lim = mode2 ? `DMX_N_BITS_M2 : `DMX_N_BITS_M1;
	wire bit_end = bit_cnt >= bit_lim - 5'h01;
	always_ff @(posedge aclk) begin
		if (!aresetn || sync_reset) begin
			bit_cnt <= 5'h00;
			line_cnt <= 2'h0;
		end else if (rise14) begin
			bit_cnt <= bit_end ? 5'h00 : bit_cnt + 5'h01;
			if (bit_end) line_cnt <= mode2 ? line_cnt + 2'h1 : 2'h0;
		end
	end
	// Line register for the remote stretcher
	always_ff @(posedge aclk) begin
		if (!aresetn) line_word <= '0;
		else if (rise14 && bit_end) line_word <= line_src;
	end
	// ---------------------------------------------
	// Sync detection and gating
	// ---------------------------------------------
	dmx_sync_e state;
	dmx_sync_e next_state;
	logic [1:0] chk_cnt;
	logic [1:0] next_chk;
	logic [1:0] miss_cnt;
	logic [1:0] next_miss;
	logic mode_prev;
	wire [4:0] misses = dmx_miss_count(seen16, sync_pat);
	wire hit = misses <= {4'h0, tol};
	// Gate open always in search, only at the slot otherwise
	wire cmp_en = t28 && (state == DMX_SEARCH || slot_end);
	wire mode_chg = mode2 != mode_prev;
	wire [1:0] chk_need = (chk_n == 2'h0) ? 2'h1 : chk_n;
	wire chk_last = (chk_cnt + 2'h1) >= chk_need;
	assign sync_reset = cmp_en && hit && state == DMX_SEARCH && !mode_chg;
	// Next state of the gating machine
	always_comb begin
		next_state = state;
		next_chk = chk_cnt;
		next_miss = miss_cnt;
		if (mode_chg) begin
			next_state = DMX_SEARCH;
			next_chk = 2'h0;
			next_miss = 2'h0;
		end else if (cmp_en) begin
			case (state)
				DMX_SEARCH: begin
					if (hit) next_state = DMX_CHECK;
					next_chk = 2'h0;
				end
				DMX_CHECK: begin
					if (!hit) next_state = DMX_SEARCH;
					else if (chk_last) next_state = DMX_LOCK;
					else next_chk = chk_cnt + 2'h1;
					next_miss = 2'h0;
				end
				DMX_LOCK: begin
					if (hit) begin
						next_miss = 2'h0;
					end else if (miss_cnt == miss_n) begin
						next_state = DMX_CHECK;
						next_chk = 2'h0;
						next_miss = 2'h0;
					end else begin
						next_miss = miss_cnt + 2'h1;
					end
				end
				default: next_state = DMX_SEARCH;
			endcase
		end
	end
	// State, counts and lamps; lamps follow the state one to one
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= DMX_SEARCH;
			chk_cnt <= 2'h0;
			miss_cnt <= 2'h0;
			mode_prev <= 1'b0;
			sync_lamps <= `DMX_LAMP_RST;
		end else begin
			state <= next_state;
			chk_cnt <= next_chk;
			miss_cnt <= next_miss;
			mode_prev <= mode2;
			sync_lamps <= 3'h1 << next_state;
		end
	end
	// ---------------------------------------------
	// Channel outputs and display
	// ---------------------------------------------
	wire cap8 = t28 && end8 && !sync_reset;
	wire cap6 = t28 && end6 && !sync_reset;
	wire mem_we = cap8 || cap6;
	wire [3:0] mem_waddr = cap8 ? `DMX_CH_IR0 + {2'h0, fcnt} : {1'b0, wcnt};
	wire [7:0] mem_wdata = cap8 ? w8 : {2'h0, w6};
	wire [7:0] mem_rdata;
	// Parallel words for the converters; IR slots are frames 0 and 1
	for (genvar g = 0; g < 8; g++) begin : g_vis
		always_ff @(posedge aclk) begin
			if (!aresetn) visual_channel_outputs[g*6 +: 6] <= 6'h00;
			else if (cap6 && wcnt == 3'(g)) visual_channel_outputs[g*6 +: 6] <= w6;
		end
	end
	for (genvar g = 0; g < 2; g++) begin : g_ir
		always_ff @(posedge aclk) begin
			if (!aresetn) infrared_channel_outputs[g*8 +: 8] <= 8'h00;
			else if (cap8 && fcnt == 2'(g)) infrared_channel_outputs[g*8 +: 8] <= w8;
		end
	end
	dmx_chan_mem #(
		.WIDTH(8),
		.DEPTH(`DMX_N_CHAN),
		.AW(4)
	) dmx_chan_mem_i (
		.aclk(aclk),
		.aresetn(aresetn),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(disp_sel),
		.rdata(mem_rdata)
	);
	// Display adds a cycle so the lamps come from a flop
	always_ff @(posedge aclk) begin
		if (!aresetn) display_leds <= 8'h00;
		else display_leds <= mem_rdata;
	end
	assign stat_word = {16'h0000, line_cnt, bit_cnt, flag, wcnt, fcnt, sync_lamps};
	// ---------------------------------------------
	// Assertions
	// ---------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	shift_x_a: assert property (rise14 |=> x_sr[0] == $past(live_x))
		else $error("X chain did not take the sampled bit");
	sync_phase_a: assert property (cap8 |=> flag)
		else $error("Flag not set after eight counts");
	vis_hold_a: assert property (flag |-> c8 == 3'h0)
		else $error("Eight counter moved during visual words");
	word_wrap_a: assert property (t28 && endw && !sync_reset |=> !flag && wcnt == 3'h0)
		else $error("Eighth word did not clear the flag");
	frame_adv_a: assert property (t28 && endw && !sync_reset |=> fcnt == $past(fcnt) + 2'h1)
		else $error("Frame counter did not advance on word wrap");
	lamp_map_a: assert property (sync_lamps == 3'h1 << state)
		else $error("Lamps disagree with sync state");
	search_reset_a: assert property (sync_reset |=> !flag && wcnt == 3'h0 && fcnt == 2'h0 ##0 bit_cnt == 5'h00 && line_cnt == 2'h0)
		else $error("Sync match did not clear counters");
	check_fail_a: assert property (state == DMX_CHECK && cmp_en && !hit && !mode_chg |=> state == DMX_SEARCH)
		else $error("Check miss did not return to search");
	lock_keep_a: assert property (state == DMX_LOCK && cmp_en && hit && !mode_chg |=> state == DMX_LOCK && miss_cnt == 2'h0)
		else $error("Good sync lost lock");
	one_bit_a: assert property (misses == 5'h01 |-> hit == tol)
		else $error("One-bit tolerance wrong");
	bit_wrap_a: assert property (rise14 && bit_end && !sync_reset |=> bit_cnt == 5'h00)
		else $error("Bit counter did not wrap");
	line_cap_a: assert property (rise14 && bit_end |=> line_word == $past(line_src))
		else $error("Line register missed its capture");
	mode_srch_a: assert property (mode_chg |=> state == DMX_SEARCH && sync_lamps == 3'h1)
		else $error("Format change did not force search");
	acq_c: cover property (state == DMX_SEARCH ##1 state == DMX_CHECK);
	lock_c: cover property (state == DMX_CHECK ##1 state == DMX_LOCK);
	drop_c: cover property (state == DMX_LOCK ##1 state == DMX_CHECK);
	disp_c: cover property (mem_we && mem_waddr == disp_sel ##2 display_leds == $past(mem_wdata, 2));
endmodule : dmx_demux

/* File: rtl/dmx_pkg.sv */
package dmx_pkg;
	// Sync gating states
	typedef enum logic [1:0] {DMX_SEARCH, DMX_CHECK, DMX_LOCK} dmx_sync_e;
	// One sample of the demodulator link
	typedef struct packed {
		logic clk28;
		logic clk14;
		logic x;
		logic y;
	} dmx_link_s;
	// Equivalence gates and a count of the bits that disagree
	function automatic logic [4:0] dmx_miss_count(input logic [15:0] seen,
		input logic [15:0] want);
		logic [15:0] eq;
		logic [4:0] n;
		eq = ~(seen ^ want);
		n = 5'h00;
		for (int i = 0; i < 16; i++) begin
			n = n + {4'h0, ~eq[i]};
		end
		return n;
	endfunction : dmx_miss_count
endpackage : dmx_pkg

/* File: rtl/dmx_selftest.sv */
`timescale 1ns/1ps
`include "dmx_cfg.svh"
module dmx_selftest import dmx_pkg::*; #(
	parameter int HALF = `DMX_ST_HALF,
	parameter int ON_CNT = `DMX_ST_ON,
	parameter int OFF_CNT = `DMX_ST_OFF
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic enable,
	input wire logic [7:0] pat8,
	input wire logic [5:0] pat6,
	output dmx_link_s link
);
	logic [7:0] cnt;
	logic [15:0] dcnt;
	logic c28;
	logic c14;
	logic [7:0] rot8;
	logic [5:0] rot6;
	// Bursts then gaps, like the scanner's duty cycle
	wire duty_on = dcnt < 16'(ON_CNT);
	wire duty_end = dcnt == 16'(ON_CNT + OFF_CNT - 1);
	wire tick = duty_on && cnt == 8'(HALF - 1);
	// Data move on the falling half so they are steady at a rise
	wire move = tick && !c28 && c14;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt <= 8'h00;
			dcnt <= 16'h0000;
			c28 <= 1'b0;
			c14 <= 1'b0;
			rot8 <= 8'h00;
			rot6 <= 6'h00;
		end else if (!enable) begin
			cnt <= 8'h00;
			dcnt <= 16'h0000;
			c28 <= 1'b0;
			c14 <= 1'b0;
			rot8 <= pat8;
			rot6 <= pat6;
		end else begin
			dcnt <= duty_end ? 16'h0000 : dcnt + 16'h0001;
			if (duty_on) cnt <= tick ? 8'h00 : cnt + 8'h01;
			if (tick) c28 <= ~c28;
			if (tick && !c28) c14 <= ~c14;
			if (move) rot8 <= {rot8[6:0], rot8[7]};
			if (move) rot6 <= {rot6[4:0], rot6[5]};
		end
	end
	// X carries the rotating pat8 bits, Y the pat6 bits; sync, IR and visual words each take bits from both
	assign link = '{clk28: c28, clk14: c14, x: rot8[7], y: rot6[5]};
endmodule : dmx_selftest

/* File: verif/dmx_demod_model.sv */
`timescale 1ns/1ps
module dmx_demod_model import dmx_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic x_lvl,
	input wire logic y_lvl,
	output dmx_link_s link
);
	logic [1:0] tick;
	// ------------------------------------------
	// Link clocks and serial data
	// ------------------------------------------
	// Clocks stand still outside frames; idle data toggles so no stale bit looks valid
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tick <= 2'h0;
			link <= '0;
		end else if (!run) begin
			tick <= 2'h0;
			link <= {2'b00, ~link.x, ~link.y};
		end else begin
			tick <= tick + 2'h1;
			if (tick == 2'h3) begin
				link.clk28 <= ~link.clk28;
				if (!link.clk28) begin
					link.clk14 <= ~link.clk14;
				end
				// Data moves on the clk14 fall, far from the sampling rise
				if (!link.clk28 && link.clk14) begin
					link.x <= x_lvl;
					link.y <= y_lvl;
				end
			end
		end
	end
endmodule : dmx_demod_model

/* File: verif/serial_demux_frame_sync_tb.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module serial_demux_frame_sync_tb import dmx_pkg::*;;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'h0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic arvalid = 1'b0;
	logic bready = 1'b1;
	logic rready = 1'b1;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rdata, rd;
	logic [47:0] vis;
	logic [15:0] ir;
	logic [55:0] line;
	logic [2:0] lamps;
	logic [7:0] leds;
	logic run = 1'b0;
	logic x_lvl = 1'b0;
	logic y_lvl = 1'b0;
	dmx_link_s lnk;
	int bad_count = 0;
	int num_checks = 0;
	// ------------------------------------------
	// Clock, design and far-side model
	// ------------------------------------------
	always #4 aclk = ~aclk;
	dmx_demux dmx_demux_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .demod_clk28(lnk.clk28), .demod_clk14(lnk.clk14),
		.demod_x(lnk.x), .demod_y(lnk.y), .visual_channel_outputs(vis),
		.infrared_channel_outputs(ir), .line_word(line), .sync_lamps(lamps),
		.display_leds(leds));
	dmx_demod_model dmx_demod_model_i (.aclk(aclk), .aresetn(aresetn), .run(run),
		.x_lvl(x_lvl), .y_lvl(y_lvl), .link(lnk));
	// ------------------------------------------
	// Bus and wait tasks
	// ------------------------------------------
	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : complete_run
	// Ready/acknowledge are registers, so reading after the edge gives the sampled value
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (int i = 0; i < 64 && !done; i++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				done = 1'b1;
				`CHK(bresp, er)
			end
		end
		if (!done) begin
			bad_count++;
			complete_run();
		end
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic done;
		done = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		for (int i = 0; i < 64 && !done; i++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				done = 1'b1;
				d = rdata;
				r = rresp;
			end
		end
		if (!done) begin
			bad_count++;
			complete_run();
		end
	endtask : axi_rd
	// Slot waits span up to two frame groups, hence the long bounds
	task automatic wait_lamps(input logic [2:0] v, input int n);
		logic seen;
		seen = 1'b0;
		for (int i = 0; i < n && !seen; i++) begin
			@(posedge aclk);
			seen = (lamps === v);
		end
		`CHK(lamps, v)
		if (!seen) complete_run();
	endtask : wait_lamps
	// ------------------------------------------
	// Main sequence
	// ------------------------------------------
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHK(lamps, 3'h1)
		`CHK(line, 56'h00_0000_0000_0000)
		axi_rd(8'h00, rd, rsp);
		`CHK(rd, 32'h0000_0008)
		axi_rd(8'h14, rd, rsp);
		`CHK(rsp, 2'h2)
		axi_wr(8'h0C, 32'h0000_0007, 2'h2);
		// Pattern one bit off the line level: exact compare must never match
		axi_wr(8'h04, 32'h0000_FF01, 2'h0);
		axi_wr(8'h00, 32'h0000_0A08, 2'h0);
		x_lvl <= 1'b1;
		run <= 1'b1;
		repeat (600) @(posedge aclk);
		`CHK(lamps, 3'h1)
		axi_wr(8'h00, 32'h0000_0A0C, 2'h0);
		wait_lamps(3'h2, 200);
		wait_lamps(3'h4, 4000);
		`CHK(ir, 16'hF0F0)
		`CHK(vis, 48'hE38E_38E3_8E38)
		`CHK(line, 56'hFF_FFFF_F000_0000)
		`CHK(leds, 8'hF0)
		axi_rd(8'h0C, rd, rsp);
		`CHK(rd[2:0], 3'h4)
		// Line goes dead: one miss drops lock, the next miss loses sync
		x_lvl <= 1'b0;
		wait_lamps(3'h2, 4000);
		wait_lamps(3'h1, 4000);
		x_lvl <= 1'b1;
		wait_lamps(3'h4, 8000);
		run <= 1'b0;
		repeat (8) @(posedge aclk);
		axi_wr(8'h00, 32'h0000_0A0E, 2'h0);
		wait_lamps(3'h1, 8);
		// Mid-run reset must clear the words and registers filled above
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		`CHK(lamps, 3'h1)
		`CHK(vis, 48'h0000_0000_0000)
		`CHK(ir, 16'h0000)
		`CHK(line, 56'h00_0000_0000_0000)
		axi_rd(8'h04, rd, rsp);
		`CHK(rd, 32'h0000_0000)
		// Self-test with dead pins: X switches all zero, Y switches all one
		axi_wr(8'h08, 32'h0000_3F00, 2'h0);
		axi_wr(8'h04, 32'h0000_00FF, 2'h0);
		axi_wr(8'h00, 32'h0000_0809, 2'h0);
		wait_lamps(3'h4, 4000);
		`CHK(ir, 16'h0F0F)
		`CHK(vis, 48'h1C71_C71C_71C7)
		`CHK(line, 56'h00_0000_0FFF_FFFF)
		`CHK(leds, 8'h0F)
		complete_run();
	end
endmodule : serial_demux_frame_sync_tb
